/* File: auto_fan_speed_control.sv */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
module auto_fan_speed_control
	import fan_pkg::*;
#(
	parameter int SLOT_CYCLES = PWM_SLOT_CYCLES,
	parameter int TICK_CYCLES = SPIN_TICK_CYCLES
)(
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	// Avalon-MM slave
	input  wire logic [9:0]       address_i,
	input  wire logic             read_i,
	input  wire logic             write_i,
	input  wire logic [31:0]      writedata_i,
	input  wire logic [3:0]       byteenable_i,
	output logic      [31:0]      readdata_o,
	output logic                  waitrequest_o,
	// Temperatures: local, remote 1, remote 2
	input  wire logic [2:0][7:0]  channel_temp_i,
	// Startup strap level code, from the pin
	input  wire logic [2:0]       startup_strap_pin_i,
	// Speed events per fan
	input  wire logic [1:0]       alarm_speed_req_i,
	input  wire logic [1:0]       hotplug_speed_req_i,
	// Fan drive
	output logic      [1:0]       fan_pwm_o
);

	if (SLOT_CYCLES < 1 || TICK_CYCLES < 1) begin : g_chk
		$error("auto_fan_speed_control: cycle counts below one");
	end

	typedef struct packed {
		logic [7:0]      spinup;
		logic [2:0][7:0] cool;
		logic [1:0][7:0] min_alarm;
		logic [2:0][7:0] on_temp;
		logic [2:0][7:0] margin;
		logic [2:0][7:0] span;
		logic            ack;
		logic [31:0]     rdata;
		logic [2:0]      strap_s1;
		logic [2:0]      strap_s2;
		logic [1:0]      settle;
		logic            strap_done;
		logic            auto_strap;
	} top_state_type;

	top_state_type   st_ff;
	top_state_type   nxt_st;
	logic [7:0]      idx;
	logic            req;
	logic            wr_take;
	logic [7:0]      wbyte;
	logic [7:0]      rd_byte;
	logic [2:0]      ch_on;
	logic [2:0][3:0] ch_steps;
	logic [1:0][3:0] target;
	logic [1:0]      demand;
	logic [1:0]      auto_fan;
	logic [1:0]      fan_spin;
	logic [1:0][3:0] fan_code;
	logic [4:0]      sum;
	logic [3:0]      cand;

	assign idx     = address_i[9:2];
	assign req     = read_i | write_i;
	// Writes land on the edge that ends the wait, as the bus expects
	assign wr_take = write_i & st_ff.ack & byteenable_i[0];
	assign wbyte   = writedata_i[7:0];

	chan_if chan [3] ();
	fan_if  fan  [2] ();

	for (genvar c = 0; c < 3; c++) begin : g_ch
		assign chan[c].temp        = channel_temp_i[c];
		assign chan[c].fan_on_temp = st_ff.on_temp[c];
		assign chan[c].span        = st_ff.span[c];
		assign chan[c].margin      = st_ff.margin[c][MARGIN_LSB +: 4];
		assign ch_on[c]            = chan[c].on;
		assign ch_steps[c]         = chan[c].steps;
		temp_loop u_loop (
			.mclk_i (mclk_i),
			.reset_i(reset_i),
			.ch     (chan[c])
		);
	end

	// Each loop stands alone; the fan follows the fastest demand
	always_comb begin
		sum      = 5'h00;
		cand     = 4'h0;
		target   = '0;
		demand   = '0;
		auto_fan = '0;
		for (int f = 0; f < 2; f++) begin
			for (int c = 0; c < 3; c++) begin
				auto_fan[f] = auto_fan[f] | st_ff.cool[c][f];
				if (st_ff.cool[c][f] && ch_on[c]) begin
					demand[f] = 1'b1;
					sum = {1'b0, st_ff.min_alarm[f][MIN_CODE_LSB +: 4]}
						+ {1'b0, ch_steps[c]};
					if (sum > 5'(FULL_DUTY_CODE)) begin
						cand = FULL_DUTY_CODE;
					end else begin
						cand = sum[3:0];
					end
					if (cand > target[f]) begin
						target[f] = cand;
					end
				end
			end
		end
	end

	for (genvar f = 0; f < 2; f++) begin : g_fan
		assign fan[f].auto_mode   = auto_fan[f];
		assign fan[f].demand      = demand[f];
		assign fan[f].target      = target[f];
		assign fan[f].skip_spin   = st_ff.spinup[SPIN_SKIP_BIT];
		assign fan[f].spin_sel    = st_ff.spinup[SPIN_SEL_LSB +: 3];
		assign fan[f].manual_code =
			st_ff.min_alarm[f][MIN_CODE_LSB +: 4];
		assign fan[f].override_en =
			alarm_speed_req_i[f] | hotplug_speed_req_i[f];
		assign fan[f].override_code = alarm_speed_req_i[f]
			? st_ff.min_alarm[f][ALARM_CODE_LSB +: 4]
			: FULL_DUTY_CODE;
		assign fan_pwm_o[f] = fan[f].pwm;
		assign fan_spin[f]  = fan[f].spinning;
		assign fan_code[f]  = fan[f].code;
		fan_drive #(
			.SLOT_CYCLES(SLOT_CYCLES),
			.TICK_CYCLES(TICK_CYCLES)
		) u_drive (
			.mclk_i (mclk_i),
			.reset_i(reset_i),
			.fan    (fan[f])
		);
	end

	// Read data, unmapped indexes read as zero
	always_comb begin
		rd_byte = 8'h00;
		if (idx == IDX_FAN1_STAT) begin
			rd_byte = {2'h0, auto_fan[0], fan_spin[0], fan_code[0]};
		end else if (idx == IDX_FAN2_STAT) begin
			rd_byte = {2'h0, auto_fan[1], fan_spin[1], fan_code[1]};
		end else if (idx == IDX_LOOP_STAT) begin
			rd_byte = {4'h0, st_ff.auto_strap, ch_on};
		end else if (idx == IDX_SPINUP) begin
			rd_byte = {4'h0, st_ff.spinup[3:0]};
		end else if (idx == IDX_COOL_LOCAL) begin
			rd_byte = st_ff.cool[0];
		end else if (idx == IDX_COOL_REM1) begin
			rd_byte = st_ff.cool[1];
		end else if (idx == IDX_COOL_REM2) begin
			rd_byte = st_ff.cool[2];
		end else if (idx == IDX_MIN_FAN1) begin
			rd_byte = st_ff.min_alarm[0];
		end else if (idx == IDX_MIN_FAN2) begin
			rd_byte = st_ff.min_alarm[1];
		end else if (idx >= IDX_ON_TEMP0 && idx < IDX_ON_TEMP0 + 8'h03) begin
			rd_byte = st_ff.on_temp[2'(idx - IDX_ON_TEMP0)];
		end else if (idx >= IDX_MARGIN0 && idx < IDX_MARGIN0 + 8'h03) begin
			rd_byte = {st_ff.margin[2'(idx - IDX_MARGIN0)][7:4], 4'h0};
		end else if (idx >= IDX_SPAN0 && idx < IDX_SPAN0 + 8'h03) begin
			rd_byte = st_ff.span[2'(idx - IDX_SPAN0)];
		end
	end

	always_comb begin
		nxt_st = st_ff;
		// One wait cycle per access keeps read data registered
		nxt_st.ack = req & ~st_ff.ack;
		// Only reads refresh the data word, so it stands between reads
		if (read_i && !st_ff.ack) begin
			nxt_st.rdata = {24'h000000, rd_byte};
		end
		// The strap is caught once, after the synchroniser has filled
		nxt_st.strap_s1 = startup_strap_pin_i;
		nxt_st.strap_s2 = st_ff.strap_s1;
		if (!st_ff.strap_done) begin
			if (st_ff.settle == STRAP_SETTLE) begin
				nxt_st.strap_done = 1'b1;
				if (st_ff.strap_s2 == STRAP_OFF_LOW
					|| st_ff.strap_s2 == STRAP_OFF_HIGH) begin
					nxt_st.auto_strap = 1'b0;
					nxt_st.cool = {3{RST_COOL_OFF}};
				end else begin
					nxt_st.auto_strap = 1'b1;
					nxt_st.cool = {3{RST_COOL_AUTO}};
				end
			end else begin
				nxt_st.settle = st_ff.settle + 2'h1;
			end
		end
		if (wr_take) begin
			if (idx == IDX_SPINUP) begin
				nxt_st.spinup = {4'h0, wbyte[3:0]};
			end else if (idx == IDX_COOL_LOCAL) begin
				nxt_st.cool[0] = wbyte;
			end else if (idx == IDX_COOL_REM1) begin
				nxt_st.cool[1] = wbyte;
			end else if (idx == IDX_COOL_REM2) begin
				nxt_st.cool[2] = wbyte;
			end else if (idx == IDX_MIN_FAN1) begin
				nxt_st.min_alarm[0] = wbyte;
			end else if (idx == IDX_MIN_FAN2) begin
				nxt_st.min_alarm[1] = wbyte;
			end else if (idx >= IDX_ON_TEMP0
				&& idx < IDX_ON_TEMP0 + 8'h03) begin
				nxt_st.on_temp[2'(idx - IDX_ON_TEMP0)] = wbyte;
			end else if (idx >= IDX_MARGIN0
				&& idx < IDX_MARGIN0 + 8'h03) begin
				nxt_st.margin[2'(idx - IDX_MARGIN0)] = {wbyte[7:4], 4'h0};
			end else if (idx >= IDX_SPAN0 && idx < IDX_SPAN0 + 8'h03) begin
				nxt_st.span[2'(idx - IDX_SPAN0)] = wbyte;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st_ff.spinup     <= RST_SPINUP;
			st_ff.cool       <= {3{RST_COOL_OFF}};
			st_ff.min_alarm  <= {2{RST_MIN_ALARM}};
			st_ff.on_temp    <= {3{RST_ON_TEMP}};
			st_ff.margin     <= {3{RST_MARGIN}};
			st_ff.span       <= {3{RST_SPAN}};
			st_ff.ack        <= 1'b0;
			st_ff.rdata      <= 32'h00000000;
			st_ff.strap_s1   <= 3'h0;
			st_ff.strap_s2   <= 3'h0;
			st_ff.settle     <= 2'h0;
			st_ff.strap_done <= 1'b0;
			st_ff.auto_strap <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign readdata_o    = st_ff.rdata;
	assign waitrequest_o = req & ~st_ff.ack;

endmodule

/* File: fan_ctl_monitor.sv */
`timescale 1ns/10ps
module fan_ctl_monitor
	import fan_pkg::*;
#(
	parameter int SLOT_CYCLES = PWM_SLOT_CYCLES,
	parameter int TICK_CYCLES = SPIN_TICK_CYCLES
)(
	// Clock and reset
	input wire logic        mclk_i,
	input wire logic        reset_i,
	// Register bus
	input wire logic [9:0]  address_i,
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0]  byteenable_i,
	input wire logic [31:0] readdata_o,
	input wire logic        waitrequest_o,
	// Speed events and fans
	input wire logic [1:0]  alarm_speed_req_i,
	input wire logic [1:0]  hotplug_speed_req_i,
	input wire logic [1:0]  fan_pwm_o
);
	// Shadow of the alarm codes, only full codes 0 and 15 are judged
	logic [1:0][3:0] alarm_code_ff;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	always_ff @(posedge mclk_i) begin
		for (int k = 0; k < 2; k++) begin
			if (reset_i)
				alarm_code_ff[k] <= 4'hf;
			else if (write_i && !waitrequest_o && byteenable_i[0]
				&& address_i[9:2] == 8'h60 + 8'(k))
				alarm_code_ff[k] <= writedata_i[7:4];
		end
	end

	sequence s_fans_quiet;
		fan_pwm_o == 2'h0 [*2];
	endsequence
	sequence s_alarm_hold(k, c);
		(alarm_speed_req_i[k] && alarm_code_ff[k] == c) [*4];
	endsequence
	sequence s_hot_hold(k);
		(hotplug_speed_req_i[k] && !alarm_speed_req_i[k]) [*4];
	endsequence

	a_wait_one_cycle: assert property (
		(read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("waitrequest held more than one cycle");
	a_wait_first: assert property (
		$rose(read_i || write_i) |-> waitrequest_o)
		else $error("request answered without its wait cycle");
	a_read_upper_zero: assert property (
		read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_read_data_hold: assert property (
		!read_i |=> $stable(readdata_o))
		else $error("read data changed without a read");
	a_quiet_after_reset: assert property (
		$fell(reset_i) |-> s_fans_quiet)
		else $error("fan drive active right after reset");
	for (genvar k = 0; k < 2; k++) begin : g_fan
		a_alarm_code_zero: assert property (
			s_alarm_hold(k, 4'h0) |-> !fan_pwm_o[k])
			else $error("alarm code zero not obeyed");
		a_alarm_code_full: assert property (
			s_alarm_hold(k, 4'hf) |-> fan_pwm_o[k])
			else $error("alarm code full not obeyed");
		a_hotplug_full: assert property (
			s_hot_hold(k) |-> fan_pwm_o[k])
			else $error("hot-plug speed not full");
	end
endmodule

bind auto_fan_speed_control fan_ctl_monitor #(
	.SLOT_CYCLES(SLOT_CYCLES),
	.TICK_CYCLES(TICK_CYCLES)
) i_fan_ctl_monitor (
	.mclk_i(mclk_i), .reset_i(reset_i), .address_i(address_i),
	.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
	.byteenable_i(byteenable_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .alarm_speed_req_i(alarm_speed_req_i),
	.hotplug_speed_req_i(hotplug_speed_req_i), .fan_pwm_o(fan_pwm_o)
);

/* File: fan_drive.sv */
`timescale 1ns/10ps
module fan_drive
	import fan_pkg::*;
#(
	parameter int SLOT_CYCLES = PWM_SLOT_CYCLES,
	parameter int TICK_CYCLES = SPIN_TICK_CYCLES
)(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Fan control
	fan_if.drive_mp  fan
);

	localparam int SW = $clog2(SLOT_CYCLES + 1);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	if (SLOT_CYCLES < 1 || TICK_CYCLES < 1) begin : g_chk
		$error("fan_drive: cycle counts must be at least one");
	end

	typedef struct packed {
		logic          demand_prev;
		logic          spinning;
		logic [10:0]   spin_left;
		logic [TW-1:0] tick_cnt;
		logic [SW-1:0] slot_cnt;
		logic [3:0]    phase;
		logic [3:0]    code;
		logic          pwm;
	} drive_state_type;

	drive_state_type st_ff;
	drive_state_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.demand_prev = fan.demand;
		if (fan.auto_mode && fan.demand && !st_ff.demand_prev
			&& !fan.skip_spin) begin
			nxt_st.spinning  = 1'b1;
			nxt_st.spin_left = spin_ticks(fan.spin_sel);
			nxt_st.tick_cnt  = '0;
		end else if (st_ff.spinning) begin
			if (!fan.demand || fan.skip_spin) begin
				nxt_st.spinning = 1'b0;
			end else if (st_ff.tick_cnt == TW'(TICK_CYCLES - 1)) begin
				nxt_st.tick_cnt  = '0;
				nxt_st.spin_left = st_ff.spin_left - 11'h001;
				if (st_ff.spin_left == 11'h001) begin
					nxt_st.spinning = 1'b0;
				end
			end else begin
				nxt_st.tick_cnt = st_ff.tick_cnt + TW'(1);
			end
		end
		// Events take over this fan only, and win over spin-up, which keeps counting
		if (fan.override_en) begin
			nxt_st.code = fan.override_code;
		end else if (!fan.auto_mode) begin
			nxt_st.code = fan.manual_code;
		end else if (!fan.demand) begin
			nxt_st.code = 4'h0;
		end else if (st_ff.spinning) begin
			nxt_st.code = FULL_DUTY_CODE;
		end else begin
			nxt_st.code = fan.target;
		end
		if (st_ff.slot_cnt == SW'(SLOT_CYCLES - 1)) begin
			nxt_st.slot_cnt = '0;
			if (st_ff.phase == 4'(DUTY_STEPS - 1)) begin
				nxt_st.phase = 4'h0;
			end else begin
				nxt_st.phase = st_ff.phase + 4'h1;
			end
		end else begin
			nxt_st.slot_cnt = st_ff.slot_cnt + SW'(1);
		end
		// Fifteen slots per period give a duty of code/15
		nxt_st.pwm = (st_ff.phase < st_ff.code);
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fan.pwm      = st_ff.pwm;
	assign fan.spinning = st_ff.spinning;
	assign fan.code     = st_ff.code;

endmodule

/* File: fan_if.sv */
`timescale 1ns/10ps
interface chan_if;
	logic [7:0] temp;
	logic [7:0] fan_on_temp;
	logic [7:0] span;
	logic [3:0] margin;
	logic       on;
	logic [3:0] steps;
	modport loop_mp (input temp, fan_on_temp, span, margin,
		output on, steps);
	modport ctl_mp (output temp, fan_on_temp, span, margin,
		input on, steps);
endinterface

interface fan_if;
	logic       auto_mode;
	logic       demand;
	logic       skip_spin;
	logic       override_en;
	logic [3:0] target;
	logic [3:0] manual_code;
	logic [3:0] override_code;
	logic [2:0] spin_sel;
	logic       pwm;
	logic       spinning;
	logic [3:0] code;
	modport drive_mp (input auto_mode, demand, skip_spin, override_en,
		target, manual_code, override_code, spin_sel,
		output pwm, spinning, code);
	modport ctl_mp (output auto_mode, demand, skip_spin, override_en,
		target, manual_code, override_code, spin_sel,
		input pwm, spinning, code);
endinterface

/* File: fan_model.sv */
`timescale 1ns/10ps
module fan_model #(
	parameter int SLOT = 2
)(
	// Clock and fan drive
	input  wire logic       mclk_i,
	input  wire logic       pwm_i,
	// Duty code seen over each full period
	output logic      [3:0] duty_o = 4'h0,
	output logic            valid_o = 1'b0
);
	int cnt = 0;
	int hi  = 0;

	// Any window of one whole period holds code times SLOT high cycles
	always @(posedge mclk_i) begin
		valid_o <= 1'b0;
		cnt = cnt + 1;
		hi = hi + int'(pwm_i);
		if (cnt == 15 * SLOT) begin
			duty_o <= 4'(hi / SLOT);
			valid_o <= 1'b1;
			cnt = 0;
			hi = 0;
		end
	end
endmodule

/* File: fan_pkg.sv */
package fan_pkg;

	// Clock and timing
	localparam int CLK_HZ           = 10_000_000;
	localparam int CLK_PER_US       = CLK_HZ / 1_000_000;
	localparam int PWM_FREQ_HZ      = 250;
	localparam int DUTY_STEPS       = 15;
	localparam int PWM_SLOT_CYCLES  = CLK_HZ / (PWM_FREQ_HZ * DUTY_STEPS);
	localparam int SPIN_TICK_US     = 15625;
	localparam int SPIN_TICK_CYCLES = SPIN_TICK_US * CLK_PER_US;
	localparam int SPAN_DIVISOR     = 10;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Register indexes, byte address is four times the index
	localparam logic [7:0] IDX_FAN1_STAT  = 8'h04;
	localparam logic [7:0] IDX_FAN2_STAT  = 8'h05;
	localparam logic [7:0] IDX_LOOP_STAT  = 8'h06;
	localparam logic [7:0] IDX_SPINUP     = 8'h0c;
	localparam logic [7:0] IDX_COOL_LOCAL = 8'h48;
	localparam logic [7:0] IDX_COOL_REM1  = 8'h49;
	localparam logic [7:0] IDX_COOL_REM2  = 8'h4a;
	localparam logic [7:0] IDX_MIN_FAN1   = 8'h60;
	localparam logic [7:0] IDX_MIN_FAN2   = 8'h61;
	localparam logic [7:0] IDX_ON_TEMP0   = 8'h80;
	localparam logic [7:0] IDX_MARGIN0    = 8'h88;
	localparam logic [7:0] IDX_SPAN0      = 8'h90;

	// Reset values
	localparam logic [7:0] RST_SPINUP     = 8'h03;
	localparam logic [7:0] RST_COOL_AUTO  = 8'h03;
	localparam logic [7:0] RST_COOL_OFF   = 8'h00;
	localparam logic [7:0] RST_MIN_ALARM  = 8'hf5;
	localparam logic [7:0] RST_ON_TEMP    = 8'h32;
	localparam logic [7:0] RST_MARGIN     = 8'h50;
	localparam logic [7:0] RST_SPAN       = 8'h28;

	// Field positions
	localparam int SPIN_SEL_LSB   = 0;
	localparam int SPIN_SKIP_BIT  = 3;
	localparam int MIN_CODE_LSB   = 0;
	localparam int ALARM_CODE_LSB = 4;
	localparam int MARGIN_LSB     = 4;
	localparam int STAT_SPIN_BIT  = 4;
	localparam int STAT_AUTO_BIT  = 5;
	localparam int STAT_STRAP_BIT = 3;

	// Duty codes and strap codes
	localparam logic [3:0] FULL_DUTY_CODE = 4'hf;
	localparam logic [2:0] STRAP_OFF_LOW  = 3'h0;
	localparam logic [2:0] STRAP_OFF_HIGH = 3'h7;

	// Spin-up length in ticks of 1/64 s
	function automatic logic [10:0] spin_ticks(input logic [2:0] sel);
		case (sel)
			3'h0:    spin_ticks = 11'h400;
			3'h1:    spin_ticks = 11'h200;
			3'h2:    spin_ticks = 11'h100;
			3'h3:    spin_ticks = 11'h080;
			3'h4:    spin_ticks = 11'h040;
			3'h5:    spin_ticks = 11'h010;
			3'h6:    spin_ticks = 11'h004;
			default: spin_ticks = 11'h001;
		endcase
	endfunction

endpackage

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	localparam int SLOT = 2;
	localparam int TICK = 4;

	logic            mclk_i              = 1'b0;
	logic            reset_i             = 1'b1;
	logic [9:0]      address_i           = 10'h0;
	logic            read_i              = 1'b0;
	logic            write_i             = 1'b0;
	logic [31:0]     writedata_i         = 32'h0;
	logic [3:0]      byteenable_i        = 4'h1;
	logic [2:0][7:0] channel_temp_i      = 24'h0;
	logic [2:0]      startup_strap_pin_i = 3'h3;
	logic [1:0]      alarm_speed_req_i   = 2'h0;
	logic [1:0]      hotplug_speed_req_i = 2'h0;
	logic [31:0]     readdata_o;
	logic            waitrequest_o;
	logic [1:0]      fan_pwm_o;
	logic [1:0][3:0] duty;
	logic [1:0]      dvalid;
	logic [31:0]     rq[$];
	logic [3:0]      dq[2][$];
	int              n_mismatch = 0;
	int              n_compared = 0;
	int              spin_tab[8] = '{1024, 512, 256, 128, 64, 16, 4, 1};
	// Index and expected value after reset
	logic [15:0]     regs[7] = '{16'h0c03, 16'h4803, 16'h4903,
		16'h4a03, 16'h60f5, 16'h61f5, 16'h2000};
	// Assign local, assign remote 1, temps, expected duty codes
	logic [47:0]     rows[7] = '{48'h0303_0000_0000, 48'h0303_2d32_0b0b,
		48'h0303_3b00_0e0e, 48'h0303_3c00_0f0f, 48'h0102_2d32_0b09,
		48'h0303_1000_0505, 48'h0303_0e00_0000};

	auto_fan_speed_control #(
		.SLOT_CYCLES(SLOT),
		.TICK_CYCLES(TICK)
	) i_auto_fan_speed_control (
		.mclk_i(mclk_i), .reset_i(reset_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .channel_temp_i(channel_temp_i),
		.startup_strap_pin_i(startup_strap_pin_i),
		.alarm_speed_req_i(alarm_speed_req_i),
		.hotplug_speed_req_i(hotplug_speed_req_i), .fan_pwm_o(fan_pwm_o)
	);
	for (genvar k = 0; k < 2; k++) begin : g_fan
		fan_model #(.SLOT(SLOT)) i_fan_model (.mclk_i(mclk_i),
			.pwm_i(fan_pwm_o[k]), .duty_o(duty[k]), .valid_o(dvalid[k]));
	end

	initial begin
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic cmp(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic timeout(input string nm);
		cmp(nm, 32'h0, 32'h1);
		wrap_up();
	endtask

	// Request stays up until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] idx, d);
		int i;
		@(posedge mclk_i);
		read_i      <= !wr;
		write_i     <= wr;
		address_i   <= {idx, 2'h0};
		writedata_i <= {24'($urandom()), d};
		i = 0;
		do begin
			@(posedge mclk_i);
			i++;
		end while (waitrequest_o !== 1'b0 && i < 50);
		if (waitrequest_o !== 1'b0)
			timeout("waitrequest");
		read_i  <= 1'b0;
		write_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, exp);
		rq.push_back({24'h0, exp});
		bus(1'b0, idx, 8'h00);
	endtask

	task automatic temps(input logic [7:0] t0, t1);
		channel_temp_i <= {8'($urandom()), t1, t0};
	endtask

	// Third full period after the call is judged, earlier ones may straddle
	task automatic check(input logic [3:0] e0, e1);
		int i;
		int seen;
		seen = 0;
		for (i = 0; i < 200 && seen < 2; i++) begin
			@(posedge mclk_i);
			if (dvalid[0] === 1'b1)
				seen++;
		end
		@(posedge mclk_i);
		dq[0].push_back(e0);
		dq[1].push_back(e1);
		for (i = 0; i < 100 && dq[1].size() > 0; i++)
			@(posedge mclk_i);
		if (dq[1].size() > 0)
			timeout("duty_period");
	endtask

	always @(posedge mclk_i) begin
		if (read_i === 1'b1 && waitrequest_o === 1'b0)
			cmp("readdata", readdata_o, rq.pop_front());
		for (int k = 0; k < 2; k++) begin
			if (dvalid[k] === 1'b1 && dq[k].size() > 0)
				cmp("duty", 32'(duty[k]), 32'(dq[k].pop_front()));
		end
	end

	initial begin
		int i;
		int n;
		logic [47:0] r;
		void'($urandom(52805));
		startup_strap_pin_i <= 3'($urandom_range(6, 1));
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		for (i = 0; i < 7; i++)
			rd(regs[i][15:8], regs[i][7:0]);
		byteenable_i <= 4'h0;
		bus(1'b1, 8'h48, 8'h00);
		byteenable_i <= 4'h1;
		rd(8'h48, 8'h03);
		$display("test registers done");
		bus(1'b1, 8'h80, 8'd20);
		bus(1'b1, 8'h81, 8'd10);
		bus(1'b1, 8'h90, 8'd40);
		bus(1'b1, 8'h91, 8'd100);
		bus(1'b1, 8'h0c, 8'h07);
		bus(1'b1, 8'h4a, 8'h00);
		for (i = 0; i < 7; i++) begin
			r = rows[i];
			bus(1'b1, 8'h48, r[47:40]);
			bus(1'b1, 8'h49, r[39:32]);
			temps(r[31:24], r[23:16]);
			check(r[11:8], r[3:0]);
		end
		$display("test control done");
		for (i = 0; i < 8; i++) begin
			n = spin_tab[i] * TICK;
			bus(1'b1, 8'h0c, 8'(i));
			temps(8'd30, 8'd0);
			if (n >= 256) begin
				repeat (n - 150) @(posedge mclk_i);
				check(4'hf, 4'hf);
				rd(8'h04, 8'h3f);
			end
			repeat (n) @(posedge mclk_i);
			check(4'h7, 4'h7);
			temps(8'd0, 8'd0);
			repeat (10) @(posedge mclk_i);
		end
		bus(1'b1, 8'h0c, 8'h0b);
		temps(8'd30, 8'd0);
		check(4'h7, 4'h7);
		rd(8'h04, 8'h27);
		$display("test spin-up done");
		alarm_speed_req_i <= 2'h1;
		check(4'hf, 4'h7);
		bus(1'b1, 8'h60, 8'h05);
		check(4'h0, 4'h7);
		hotplug_speed_req_i <= 2'h2;
		check(4'h0, 4'hf);
		alarm_speed_req_i <= 2'h3;
		bus(1'b1, 8'h61, 8'h25);
		check(4'h0, 4'h2);
		alarm_speed_req_i   <= 2'h0;
		hotplug_speed_req_i <= 2'h0;
		check(4'h7, 4'h7);
		$display("test overrides done");
		reset_i             <= 1'b1;
		startup_strap_pin_i <= 3'(7 * $urandom_range(1, 0));
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		rd(8'h48, 8'h00);
		temps(8'd60, 8'd60);
		check(4'h5, 4'h5);
		rd(8'h04, 8'h05);
		$display("test strap done");
		wrap_up();
	end
endmodule

/* File: temp_loop.sv */
`timescale 1ns/10ps
module temp_loop
	import fan_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Channel
	chan_if.loop_mp  ch
);

	typedef struct packed {
		logic       on;
		logic [3:0] steps;
	} loop_state_type;

	loop_state_type st_ff;
	loop_state_type nxt_st;
	logic [8:0]     rise;
	logic [12:0]    scaled;
	logic [12:0]    quot;

	always_comb begin
		nxt_st = st_ff;
		rise   = {1'b0, ch.temp} - {1'b0, ch.fan_on_temp};
		scaled = 13'(rise[7:0]) * 13'(SPAN_DIVISOR);
		// Zero span would divide by zero, treat it as a step to full speed
		if (ch.span == 8'h00) begin
			quot = 13'(FULL_DUTY_CODE);
		end else begin
			quot = scaled / 13'(ch.span);
		end
		if (!st_ff.on && ch.temp > ch.fan_on_temp) begin
			nxt_st.on = 1'b1;
		end else if (st_ff.on && ({1'b0, ch.temp} + {5'h00, ch.margin}
			< {1'b0, ch.fan_on_temp})) begin
			nxt_st.on = 1'b0;
		end
		if (ch.temp <= ch.fan_on_temp) begin
			nxt_st.steps = 4'h0;
		end else if (quot > 13'(FULL_DUTY_CODE)) begin
			nxt_st.steps = FULL_DUTY_CODE;
		end else begin
			nxt_st.steps = quot[3:0];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ch.on    = st_ff.on;
	assign ch.steps = st_ff.steps;

endmodule
